// ---- common/sweep_consts.svh ----
`ifndef SWEEP_CONSTS_SVH
`define SWEEP_CONSTS_SVH

// Register indices on the plain register port.
`define REG_FREQ_MIN 4'h0
`define REG_FREQ_MAX 4'h1
`define REG_STEP_MIN 4'h2
`define REG_CONFIG 4'h3
`define REG_STATUS 4'h4

// Field positions.
`define CFG_LIMIT_BIT 8
`define CFG_EXT_BIT 9
`define STAT_BUSY_BIT 0

// Reset values.
`define FREQ_MIN_RST 32'h00002328
`define FREQ_MAX_RST 32'hb2d05e00
`define STEP_MIN_RST 32'h00000001
`define ATT_MAX_RST 8'h2d

// Argument limits.
`define HOLD_MAX_MS 32'h00007530
`define BAND_SPLIT_HZ 32'h01c9c380
`define TABLE_DEPTH 7'h64
`define NOT_MEASURED_VALUE 16'h8044

// Reply texts, left aligned, eleven characters at most.
`define TEXT_ACCEPT 88'h5346443d4f4b0d0a000000
`define TEXT_ERROR 88'h5346443d45525220000d0a
`define TEXT_END 88'h5346445f454e440d0a0000
`define TEXT_ABORT 88'h53424b3d4f4b0d0a000000
`define LEN_ACCEPT 4'h8
`define LEN_ERROR 4'hb
`define LEN_END 4'h9
`define LEN_ABORT 4'h8
`define ERR_DIGIT_POS 4'h8
`define ASCII_ZERO 8'h30

`endif

// ---- common/sweep_pkg.sv ----
package sweep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MSG = 3'b001,
    ST_FIND = 3'b010,
    ST_TUNE = 3'b011,
    ST_WAIT = 3'b100,
    ST_SEND = 3'b101
  } sweep_state_e;

  typedef enum logic [1:0] {
    MSG_ACCEPT = 2'b00,
    MSG_ERROR = 2'b01,
    MSG_END = 2'b10,
    MSG_ABORT = 2'b11
  } msg_kind_e;

  typedef struct packed {
    sweep_state_e st;
    msg_kind_e kind;
    logic [3:0] code;
    logic [3:0] cidx;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [31:0] fmin;
    logic [31:0] fmax;
    logic [31:0] min_step;
    logic [7:0] max_att;
    logic limit_on;
    logic ext_opt;
    logic [31:0] rdata;
    logic [31:0] start;
    logic [31:0] stop;
    logic [31:0] step;
    logic [31:0] freq;
    logic tbl_mode;
    logic [6:0] tidx;
    logic [6:0] tcnt;
    logic [5:0] mask;
    logic smart;
    logic [15:0] hold;
    logic [15:0] dwell;
    logic dwell_min;
    logic [3:0] rbw;
    logic [7:0] floor;
    logic preamp;
    logic presel;
    logic att_auto;
    logic tune;
    logic [2:0] didx;
    logic hi;
    logic [95:0] vals;
    logic [5:0] meas;
    logic abort_pend;
    logic [3:0] last_err;
  } sweep_s;

endpackage : sweep_pkg

// ---- src/sweep_command_interpreter.sv ----
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sweep_consts.svh"

module sweep_command_interpreter
  import sweep_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Parsed sweep setup command.
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [31:0] cmd_start_i,
  input wire logic [31:0] cmd_stop_i,
  input wire logic [31:0] cmd_step_i,
  input wire logic [63:0] cmd_det_i,
  input wire logic [3:0] cmd_det_len_i,
  input wire logic [31:0] cmd_hold_i,
  input wire logic [7:0] cmd_rbw_i,
  input wire logic [15:0] cmd_att_i,
  input wire logic [23:0] cmd_preamp_i,
  input wire logic [1:0] cmd_preamp_len_i,
  input wire logic [23:0] cmd_presel_i,
  input wire logic [1:0] cmd_presel_len_i,
  input wire logic cmd_dwell_present_i,
  input wire logic [15:0] cmd_dwell_i,
  // Abort command strobe.
  input wire logic abort_i,
  // Scan table writes.
  input wire logic tbl_wr_i,
  input wire logic [6:0] tbl_idx_i,
  input wire logic [31:0] tbl_freq_i,
  // Measurement front end.
  output logic tune_o,
  output logic [31:0] tune_freq_o,
  output logic [5:0] det_mask_o,
  output logic smart_o,
  output logic [15:0] hold_ms_o,
  output logic [15:0] dwell_ms_o,
  output logic dwell_min_o,
  output logic [3:0] rbw_o,
  output logic att_auto_o,
  output logic [7:0] att_floor_o,
  output logic preamp_o,
  output logic presel_o,
  output logic sweeping_o,
  input wire logic meas_valid_i,
  input wire logic [95:0] meas_values_i,
  input wire logic [5:0] meas_done_i,
  // Reply byte stream.
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);

  sweep_s r;
  sweep_s n;
  logic [31:0] tbl [100];
  logic [6:0] dec [8];
  logic [5:0] det_mask;
  logic det_smart;
  logic det_bad;
  logic [2:0] alt_cnt;
  logic [1:0] pa_chk;
  logic [1:0] ps_chk;
  logic [3:0] chk_err;
  logic e1, e2, e3, e4, e5, e6;
  logic [31:0] step_eff;
  logic [32:0] freq_sum;
  logic [31:0] tbl_entry;
  logic tx_free;
  logic [87:0] text;
  logic [3:0] text_len;
  logic [15:0] cur_val;

  // Letter decode: bit order matches the output order, bit 6 is the smart letter.
  function automatic logic [6:0] letter_code(input logic [7:0] c);
    case (c)
      8'h50: letter_code = 7'h01;
      8'h51: letter_code = 7'h02;
      8'h52: letter_code = 7'h04;
      8'h41: letter_code = 7'h08;
      8'h4e: letter_code = 7'h10;
      8'h43: letter_code = 7'h20;
      8'h53: letter_code = 7'h40;
      default: letter_code = 7'h00;
    endcase
  endfunction : letter_code

  // Returns {valid, on} for an ON or OFF string in any case.
  function automatic logic [1:0] on_off(input logic [23:0] s, input logic [1:0] len);
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    c0 = s[7:0] & 8'hdf;
    c1 = s[15:8] & 8'hdf;
    c2 = s[23:16] & 8'hdf;
    if (len == 2'h2 && c0 == 8'h4f && c1 == 8'h4e) begin
      on_off = 2'h3;
    end else if (len == 2'h3 && c0 == 8'h4f && c1 == 8'h46 && c2 == 8'h46) begin
      on_off = 2'h2;
    end else begin
      on_off = 2'h0;
    end
  endfunction : on_off

  for (genvar gi = 0; gi < 8; gi++) begin : g_letter
    assign dec[gi] = letter_code(cmd_det_i[8*gi +: 8]);
  end

  always_comb begin
    det_mask = 6'h00;
    det_smart = (cmd_det_len_i != 4'h0) && dec[0][6];
    det_bad = (cmd_det_len_i == 4'h0) || (cmd_det_len_i > 4'h8);
    alt_cnt = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < cmd_det_len_i) begin
        if (dec[i] == 7'h00) det_bad = 1'b1;
        if (dec[i][6] && i != 0) det_bad = 1'b1;
        if (det_smart && dec[i][0]) det_bad = 1'b1;
        det_mask = det_mask | dec[i][5:0];
      end
    end
    for (int i = 1; i < 6; i++) begin
      alt_cnt = alt_cnt + 3'(det_mask[i]);
    end
  end

  assign pa_chk = on_off(cmd_preamp_i, cmd_preamp_len_i);
  assign ps_chk = on_off(cmd_presel_i, cmd_presel_len_i);
  assign e1 = (cmd_start_i < r.fmin) || (cmd_stop_i > r.fmax)
      || (cmd_start_i > cmd_stop_i);
  assign e2 = (!cmd_step_i[31] && cmd_step_i != 32'h0 && cmd_step_i < r.min_step)
      || (cmd_step_i == 32'h0 && r.tcnt < 7'h02);
  assign e3 = det_bad || (det_smart && (!r.limit_on || alt_cnt != 3'h1));
  assign e4 = cmd_hold_i[31] || (cmd_hold_i > `HOLD_MAX_MS);
  assign e5 = (cmd_rbw_i == 8'h00) || (cmd_rbw_i > 8'h0a)
      || ((cmd_rbw_i == 8'h09 || cmd_rbw_i == 8'h0a)
          && (!r.ext_opt || cmd_start_i <= `BAND_SPLIT_HZ))
      || (cmd_rbw_i == 8'h07 && cmd_stop_i > `BAND_SPLIT_HZ)
      || (det_mask[1] && cmd_rbw_i != 8'h06 && cmd_rbw_i != 8'h07
          && cmd_rbw_i != 8'h0a);
  assign e6 = cmd_att_i[15] || (cmd_att_i > {8'h00, r.max_att})
      || ((cmd_att_i[7:0] % 8'h05) != 8'h00);
  assign chk_err = e1 ? 4'h1 : e2 ? 4'h2 : e3 ? 4'h3 : e4 ? 4'h4 : e5 ? 4'h5 : e6 ? 4'h6
      : !pa_chk[1] ? 4'h7 : !ps_chk[1] ? 4'h8 : 4'h0;

  assign step_eff = r.step[31] ? r.min_step : r.step;
  assign freq_sum = {1'b0, r.freq} + {1'b0, step_eff};
  assign tbl_entry = tbl[r.tidx];
  assign tx_free = !r.tx_valid || tx_ready_i;
  assign cur_val = r.meas[r.didx] ? r.vals[16*r.didx +: 16] : `NOT_MEASURED_VALUE;

  always_comb begin
    case (r.kind)
      MSG_ACCEPT: begin
        text = `TEXT_ACCEPT;
        text_len = `LEN_ACCEPT;
      end
      MSG_ERROR: begin
        text = `TEXT_ERROR;
        text_len = `LEN_ERROR;
      end
      MSG_END: begin
        text = `TEXT_END;
        text_len = `LEN_END;
      end
      default: begin
        text = `TEXT_ABORT;
        text_len = `LEN_ABORT;
      end
    endcase
  end

  always_comb begin
    n = r;
    n.tune = 1'b0;
    n.rdata = 32'h0;
    if (r.tx_valid && tx_ready_i) n.tx_valid = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_FREQ_MIN: n.fmin = reg_wdata_i;
        `REG_FREQ_MAX: n.fmax = reg_wdata_i;
        `REG_STEP_MIN: n.min_step = reg_wdata_i;
        `REG_CONFIG: begin
          n.max_att = reg_wdata_i[7:0];
          n.limit_on = reg_wdata_i[`CFG_LIMIT_BIT];
          n.ext_opt = reg_wdata_i[`CFG_EXT_BIT];
        end
        default: n.rdata = 32'h0;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_FREQ_MIN: n.rdata = r.fmin;
        `REG_FREQ_MAX: n.rdata = r.fmax;
        `REG_STEP_MIN: n.rdata = r.min_step;
        `REG_CONFIG: n.rdata = {22'h0, r.ext_opt, r.limit_on, r.max_att};
        `REG_STATUS: n.rdata = {17'h0, r.tcnt, r.last_err, 3'h0, (r.st != ST_IDLE)};
        default: n.rdata = 32'h0;
      endcase
    end
    if (tbl_wr_i && tbl_idx_i < `TABLE_DEPTH && r.st == ST_IDLE) begin
      n.tcnt = tbl_idx_i + 7'h01;
    end
    if (abort_i && r.att_auto) n.abort_pend = 1'b1;
    case (r.st)
      ST_IDLE: begin
        n.abort_pend = 1'b0;
        if (cmd_valid_i) begin
          n.st = ST_MSG;
          n.cidx = 4'h0;
          n.code = chk_err;
          n.last_err = chk_err;
          n.kind = (chk_err == 4'h0) ? MSG_ACCEPT : MSG_ERROR;
          if (chk_err == 4'h0) begin
            n.start = cmd_start_i;
            n.stop = cmd_stop_i;
            n.step = cmd_step_i;
            n.freq = cmd_start_i;
            n.tbl_mode = (cmd_step_i == 32'h0);
            n.tidx = 7'h00;
            n.smart = det_smart;
            n.mask = det_smart ? (det_mask | 6'h01) : det_mask;
            n.hold = cmd_hold_i[15:0];
            n.dwell = cmd_dwell_present_i ? cmd_dwell_i : 16'h0000;
            n.dwell_min = !cmd_dwell_present_i || !det_smart;
            n.rbw = cmd_rbw_i[3:0];
            n.floor = cmd_att_i[7:0];
            n.preamp = pa_chk[0];
            n.presel = ps_chk[0];
            n.att_auto = 1'b1;
          end
        end
      end
      ST_MSG: begin
        if (tx_free) begin
          if (r.cidx < text_len) begin
            n.tx_valid = 1'b1;
            n.tx_data = (r.kind == MSG_ERROR && r.cidx == `ERR_DIGIT_POS)
                ? (`ASCII_ZERO + {4'h0, r.code}) : text[8'd87 - {r.cidx, 3'h0} -: 8];
            n.cidx = r.cidx + 4'h1;
          end else if (r.kind == MSG_ACCEPT) begin
            n.st = r.abort_pend ? ST_MSG : (r.tbl_mode ? ST_FIND : ST_TUNE);
            n.kind = MSG_ABORT;
            n.cidx = 4'h0;
          end else begin
            n.st = ST_IDLE;
            n.att_auto = 1'b0;
          end
        end
      end
      ST_FIND: begin
        if (r.abort_pend) begin
          n.st = ST_MSG;
          n.kind = MSG_ABORT;
          n.cidx = 4'h0;
        end else if (r.tidx >= r.tcnt) begin
          n.st = ST_MSG;
          n.kind = MSG_END;
          n.cidx = 4'h0;
        end else if (tbl_entry < r.start || tbl_entry > r.stop) begin
          n.tidx = r.tidx + 7'h01;
        end else begin
          n.freq = tbl_entry;
          n.tidx = r.tidx + 7'h01;
          n.st = ST_TUNE;
        end
      end
      ST_TUNE: begin
        if (r.abort_pend) begin
          n.st = ST_MSG;
          n.kind = MSG_ABORT;
          n.cidx = 4'h0;
        end else begin
          n.tune = 1'b1;
          n.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (r.abort_pend) begin
          n.st = ST_MSG;
          n.kind = MSG_ABORT;
          n.cidx = 4'h0;
        end else if (meas_valid_i) begin
          n.vals = meas_values_i;
          n.meas = meas_done_i;
          n.didx = 3'h0;
          n.hi = 1'b0;
          n.st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_free) begin
          if (r.abort_pend) begin
            n.st = ST_MSG;
            n.kind = MSG_ABORT;
            n.cidx = 4'h0;
          end else if (r.didx == 3'h6) begin
            n.freq = freq_sum[31:0];
            if (r.tbl_mode) begin
              n.st = ST_FIND;
            end else if (freq_sum > {1'b0, r.stop}) begin
              n.st = ST_MSG;
              n.kind = MSG_END;
              n.cidx = 4'h0;
            end else begin
              n.st = ST_TUNE;
            end
          end else if (!r.mask[r.didx]) begin
            n.didx = r.didx + 3'h1;
          end else begin
            n.tx_valid = 1'b1;
            n.tx_data = r.hi ? cur_val[15:8] : cur_val[7:0];
            n.hi = !r.hi;
            if (r.hi) n.didx = r.didx + 3'h1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.fmin <= `FREQ_MIN_RST;
      r.fmax <= `FREQ_MAX_RST;
      r.min_step <= `STEP_MIN_RST;
      r.max_att <= `ATT_MAX_RST;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (tbl_wr_i && tbl_idx_i < `TABLE_DEPTH && r.st == ST_IDLE) begin
      tbl[tbl_idx_i] <= tbl_freq_i;
    end
  end

  assign cmd_ready_o = (r.st == ST_IDLE);
  assign reg_rdata_o = r.rdata;
  assign tune_o = r.tune;
  assign tune_freq_o = r.freq;
  assign det_mask_o = r.mask;
  assign smart_o = r.smart;
  assign hold_ms_o = r.hold;
  assign dwell_ms_o = r.dwell;
  assign dwell_min_o = r.dwell_min;
  assign rbw_o = r.rbw;
  assign att_auto_o = r.att_auto;
  assign att_floor_o = r.floor;
  assign preamp_o = r.preamp;
  assign presel_o = r.presel;
  assign sweeping_o = r.att_auto;
  assign tx_data_o = r.tx_data;
  assign tx_valid_o = r.tx_valid;

  a_err_no_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.st == ST_IDLE && cmd_valid_i && chk_err != 4'h0)
    |=> (r.kind == MSG_ERROR && r.code == $past(chk_err) && !r.att_auto))
    else $error("error reply missing or sweep started");
  a_ok_starts: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.st == ST_IDLE && cmd_valid_i && chk_err == 4'h0)
    |=> (r.kind == MSG_ACCEPT && r.att_auto && r.freq == $past(cmd_start_i)))
    else $error("valid command did not start a sweep");
  a_tune_in_range: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    r.tune |-> (r.freq >= r.start && r.freq <= r.stop))
    else $error("tuned frequency outside sweep range");
  a_att_auto_floor: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.st != ST_IDLE && r.kind != MSG_ERROR)
    |-> (att_auto_o && (!$past(att_auto_o) || $stable(att_floor_o))))
    else $error("attenuator left automatic or floor changed during sweep");
  a_smart_two_dets: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.smart && r.att_auto) |-> (r.mask[0] && $countones(r.mask) == 2))
    else $error("smart mode detector set is not peak plus one");
  a_tx_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.tx_valid && !tx_ready_i) |=> (r.tx_valid && $stable(r.tx_data)))
    else $error("reply byte dropped or changed while stalled");
  a_order_fixed: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.st == ST_SEND && $past(r.st) == ST_SEND) |-> (r.didx >= $past(r.didx)))
    else $error("detector order went backwards");
  a_abort_no_tune: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.abort_pend && r.st != ST_IDLE) |=> !r.tune)
    else $error("tuning continued after abort");
  a_not_measured_value_sub: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (r.st == ST_SEND && tx_free && !r.abort_pend && r.didx < 3'h6 && r.mask[r.didx]
     && !r.meas[r.didx] && !r.hi) |=> (r.tx_data == 8'h44))
    else $error("unmeasured detector not replaced by reserved value");

endmodule : sweep_command_interpreter

`default_nettype wire

// ---- verification/host_link_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Host side of the reply stream: collects every reply byte and stalls one cycle in three.
module host_link_model (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Reply stream.
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] rx_q[$];
  logic [1:0] stall_cnt_reg;

  assign tx_ready_o = (stall_cnt_reg != 2'h2);

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stall_cnt_reg <= 2'h0;
    end else begin
      stall_cnt_reg <= (stall_cnt_reg == 2'h2) ? 2'h0 : stall_cnt_reg + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
        rx_q.push_back(tx_data_i);
      end
    end
  end
endmodule : host_link_model

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sweep_consts.svh"
`define check_eq(what, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
  end \
end

module tb_top;
  localparam logic [31:0] F1 = 32'h000f4240;
  localparam logic [31:0] F2 = 32'h000f4254;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic cmd_valid_i = 1'b0;
  logic cmd_ready_o;
  logic [31:0] cmd_start_i = 32'h0, cmd_stop_i = 32'h0;
  logic [31:0] cmd_step_i = 32'h0, cmd_hold_i = 32'h0;
  logic [63:0] cmd_det_i = 64'h0;
  logic [3:0] cmd_det_len_i = 4'h0;
  logic [7:0] cmd_rbw_i = 8'h0;
  logic [15:0] cmd_att_i = 16'h0, cmd_dwell_i = 16'h0;
  logic [23:0] cmd_preamp_i = 24'h0, cmd_presel_i = 24'h0;
  logic [1:0] cmd_preamp_len_i = 2'h0, cmd_presel_len_i = 2'h0;
  logic cmd_dwell_present_i = 1'b0, abort_i = 1'b0, tbl_wr_i = 1'b0;
  logic [6:0] tbl_idx_i = 7'h0;
  logic [31:0] tbl_freq_i = 32'h0;
  logic tune_o, smart_o, dwell_min_o, att_auto_o, preamp_o, presel_o;
  logic sweeping_o, tx_valid_o, tx_ready_i;
  logic [31:0] tune_freq_o;
  logic [5:0] det_mask_o;
  logic [15:0] hold_ms_o, dwell_ms_o;
  logic [3:0] rbw_o;
  logic [7:0] att_floor_o, tx_data_o;
  logic meas_valid_i = 1'b0, pend = 1'b0;
  logic [95:0] meas_values_i;
  logic [31:0] fq = 32'h0;
  logic [7:0] exp_q[$];
  int n_errors = 0, checks = 0, cycles = 0, n_tunes = 0;

  sweep_command_interpreter sweep_command_interpreter_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_start_i(cmd_start_i), .cmd_stop_i(cmd_stop_i), .cmd_step_i(cmd_step_i),
    .cmd_det_i(cmd_det_i), .cmd_det_len_i(cmd_det_len_i), .cmd_hold_i(cmd_hold_i),
    .cmd_rbw_i(cmd_rbw_i), .cmd_att_i(cmd_att_i), .cmd_preamp_i(cmd_preamp_i),
    .cmd_preamp_len_i(cmd_preamp_len_i), .cmd_presel_i(cmd_presel_i),
    .cmd_presel_len_i(cmd_presel_len_i), .cmd_dwell_present_i(cmd_dwell_present_i),
    .cmd_dwell_i(cmd_dwell_i), .abort_i(abort_i), .tbl_wr_i(tbl_wr_i),
    .tbl_idx_i(tbl_idx_i), .tbl_freq_i(tbl_freq_i), .tune_o(tune_o),
    .tune_freq_o(tune_freq_o), .det_mask_o(det_mask_o), .smart_o(smart_o),
    .hold_ms_o(hold_ms_o), .dwell_ms_o(dwell_ms_o), .dwell_min_o(dwell_min_o),
    .rbw_o(rbw_o), .att_auto_o(att_auto_o), .att_floor_o(att_floor_o),
    .preamp_o(preamp_o), .presel_o(presel_o), .sweeping_o(sweeping_o),
    .meas_valid_i(meas_valid_i), .meas_values_i(meas_values_i), .meas_done_i(6'h37),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i)
  );

  host_link_model host_link_model_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i)
  );

  always #20 clk_sys_i = ~clk_sys_i;

  // Front end answers two cycles after each tune; the average detector never completes.
  always @(posedge clk_sys_i) begin
    pend <= tune_o;
    meas_valid_i <= pend;
    if (tune_o) begin
      fq <= tune_freq_o;
      n_tunes <= n_tunes + 1;
    end
  end

  always_comb begin
    for (int k = 0; k < 6; k++) meas_values_i[16*k+:16] = fq[15:0] + 16'(k);
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("timeout reached");
      finish_test();
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  function automatic logic [63:0] pk(input string s);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < s.len(); i++) r[8*i+:8] = s[i];
    return r;
  endfunction : pk

  task push_text(input logic [87:0] t, input int len);
    for (int i = 0; i < len; i++) exp_q.push_back(t[87 - 8 * i -: 8]);
  endtask : push_text

  task tbl_put(input logic [6:0] i, input logic [31:0] f);
    @(posedge clk_sys_i);
    tbl_wr_i <= 1'b1;
    tbl_idx_i <= i;
    tbl_freq_i <= f;
    @(posedge clk_sys_i);
    tbl_wr_i <= 1'b0;
  endtask : tbl_put

  task push16(input logic [15:0] v);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
  endtask : push16

  task send_cmd(input logic [31:0] st, sp, stp, input string det, input logic [31:0] hold,
                input logic [7:0] rbw, input logic [15:0] att, input string pa, ps,
                input logic dp, input logic [15:0] dw);
    @(posedge clk_sys_i);
    host_link_model_inst.rx_q.delete();
    exp_q.delete();
    cmd_start_i <= st;
    cmd_stop_i <= sp;
    cmd_step_i <= stp;
    cmd_det_i <= pk(det);
    cmd_det_len_i <= 4'(det.len());
    cmd_hold_i <= hold;
    cmd_rbw_i <= rbw;
    cmd_att_i <= att;
    cmd_preamp_i <= 24'(pk(pa));
    cmd_preamp_len_i <= 2'(pa.len());
    cmd_presel_i <= 24'(pk(ps));
    cmd_presel_len_i <= 2'(ps.len());
    cmd_dwell_present_i <= dp;
    cmd_dwell_i <= dw;
    cmd_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
  endtask : send_cmd

  task wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk_sys_i);
    while (cmd_ready_o !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
  endtask : wait_idle

  task wait_tune;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (tune_o !== 1'b1 && n < 500);
  endtask : wait_tune

  task cmp_rx(input string what, input int base);
    `check_eq(what, 1, (host_link_model_inst.rx_q.size() >= base + exp_q.size()))
    if (host_link_model_inst.rx_q.size() >= base + exp_q.size())
      foreach (exp_q[i]) `check_eq(what, exp_q[i], host_link_model_inst.rx_q[base + i])
  endtask : cmp_rx

  task expect_err(input int n);
    int t0;
    t0 = n_tunes;
    wait_idle();
    push_text(`TEXT_ERROR | {64'h0, `ASCII_ZERO + 8'(n), 16'h0}, `LEN_ERROR);
    `check_eq("error reply length", exp_q.size(), host_link_model_inst.rx_q.size())
    cmp_rx("error reply", 0);
    `check_eq("no tune after error", t0, n_tunes)
  endtask : expect_err

  task t_regs;
    logic [31:0] d;
    reg_rd(4'h0, d);
    `check_eq("freq min", 32'h00002328, d)
    reg_rd(4'h1, d);
    `check_eq("freq max", 32'hb2d05e00, d)
    reg_rd(4'h2, d);
    `check_eq("step min", 32'h00000001, d)
    reg_rd(4'h3, d);
    `check_eq("config", 32'h0000002d, d)
    reg_wr(4'h4, 32'hffffffff);
    reg_rd(4'h4, d);
    `check_eq("status read only", 32'h00000000, d)
    reg_rd(4'h7, d);
    `check_eq("unmapped read", 32'h00000000, d)
    $display("test registers done");
  endtask : t_regs

  task t_errors;
    logic [31:0] d;
    tbl_put(7'h00, F1);
    reg_rd(4'h4, d);
    `check_eq("table count", 32'h00000100, d)
    send_cmd(32'h64, F2, 32'h0a, "RAP", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(1);
    send_cmd(F2, F1, 32'h0a, "RAP", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(1);
    send_cmd(F1, F2, 32'h0, "RAP", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(2);
    send_cmd(F1, F2, 32'h0a, "X", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(3);
    send_cmd(F1, F2, 32'h0a, "SQ", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(3);
    send_cmd(F1, F2, 32'h0a, "RAP", 32'h7531, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(4);
    send_cmd(F1, F2, 32'h0a, "RAP", 32'hffffffff, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    expect_err(4);
    send_cmd(F1, F2, 32'h0a, "RAP", 0, 8'h09, 16'h0a, "OFF", "on", 0, 0);
    expect_err(5);
    send_cmd(F1, F2, 32'h0a, "RAP", 0, 8'h06, 16'h07, "OFF", "on", 0, 0);
    expect_err(6);
    send_cmd(F1, F2, 32'h0a, "RAP", 0, 8'h06, 16'h0a, "OF", "on", 0, 0);
    expect_err(7);
    send_cmd(F1, F2, 32'h0a, "RAP", 0, 8'h06, 16'h0a, "OFF", "YES", 0, 0);
    expect_err(8);
    $display("test errors done");
  endtask : t_errors

  task t_sweep;
    int t0;
    t0 = n_tunes;
    send_cmd(F1, F2, 32'h0a, "RAP", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    wait_tune();
    `check_eq("first tune", F1, tune_freq_o)
    `check_eq("mask", 6'h0d, det_mask_o)
    `check_eq("attenuator auto", 2'b11, {att_auto_o, sweeping_o})
    `check_eq("floor", 8'h0a, att_floor_o)
    `check_eq("bandwidth", 4'h6, rbw_o)
    `check_eq("switches", 2'b01, {preamp_o, presel_o})
    `check_eq("dwell minimum", 2'b01, {smart_o, dwell_min_o})
    `check_eq("hold", 16'h0000, hold_ms_o)
    wait_idle();
    push_text(`TEXT_ACCEPT, `LEN_ACCEPT);
    for (int i = 0; i < 3; i++) begin
      push16(16'h4240 + 16'(10 * i));
      push16(16'h4242 + 16'(10 * i));
      push16(16'h8044);
    end
    push_text(`TEXT_END, `LEN_END);
    `check_eq("stream length", exp_q.size(), host_link_model_inst.rx_q.size())
    cmp_rx("sweep stream", 0);
    `check_eq("step count", t0 + 3, n_tunes)
    `check_eq("attenuator released", 2'b00, {att_auto_o, sweeping_o})
    $display("test sweep done");
  endtask : t_sweep

  // Entry 0 holds F1; entries 1 and 3 lie outside the range and must be skipped.
  task t_table;
    int t0;
    t0 = n_tunes;
    tbl_put(7'h01, F2 + 32'h64);
    tbl_put(7'h02, F2);
    tbl_put(7'h03, 32'h64);
    send_cmd(F1, F2, 32'h0, "P", 0, 8'h06, 16'h0a, "OFF", "on", 0, 0);
    wait_idle();
    push_text(`TEXT_ACCEPT, `LEN_ACCEPT);
    push16(16'h4240);
    push16(16'h4254);
    push_text(`TEXT_END, `LEN_END);
    `check_eq("table stream length", exp_q.size(), host_link_model_inst.rx_q.size())
    cmp_rx("table stream", 0);
    `check_eq("table tunes", t0 + 2, n_tunes)
    $display("test table done");
  endtask : t_table

  task t_abort;
    logic [31:0] d;
    reg_wr(4'h3, 32'h0000012d);
    reg_rd(4'h3, d);
    `check_eq("config limit", 32'h0000012d, d)
    send_cmd(F1, 32'h001e8480, 32'h0a, "SQ", 32'h3e8, 8'h06, 16'h0, "on", "OFF", 1, 16'h64);
    wait_tune();
    `check_eq("smart mask", 7'h43, {smart_o, det_mask_o})
    `check_eq("smart hold", 16'h03e8, hold_ms_o)
    `check_eq("smart dwell", 17'h00064, {dwell_min_o, dwell_ms_o})
    `check_eq("smart switches", 2'b10, {preamp_o, presel_o})
    wait_tune();
    @(posedge clk_sys_i);
    abort_i <= 1'b1;
    @(posedge clk_sys_i);
    abort_i <= 1'b0;
    wait_idle();
    `check_eq("abort stream length", 20, host_link_model_inst.rx_q.size())
    push_text(`TEXT_ACCEPT, `LEN_ACCEPT);
    push16(16'h4240);
    push16(16'h4241);
    cmp_rx("abort head", 0);
    exp_q.delete();
    push_text(`TEXT_ABORT, `LEN_ABORT);
    cmp_rx("abort tail", host_link_model_inst.rx_q.size() - 8);
    `check_eq("abort released", 1'b0, att_auto_o)
    $display("test abort done");
  endtask : t_abort

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_regs();
    t_errors();
    t_sweep();
    t_table();
    t_abort();
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
